/* link_sync_ctrl.sv */
// link sync request selection and interpretation, plus reference edge detect
`timescale 1ns/1ps

// Contract
// - select 0 takes single-ended low sync pin
// - 64b/66b ignores sync for link start
// - low sync request starts code group sync
// - rising sync request starts lane alignment
// - select 1 takes differential marker pair
// - reference input rising edges time the link
// - marker pair read active low too
// - marker pair honoured only when enabled
module link_sync_ctrl
  import sync_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire sync_pkg::sync_cfg_t  cfg,
  input  wire sync_pkg::sync_pins_t pins,
  output sync_pkg::sync_ctl_t       ctl,
  output logic                      sync_req_n
);
  import sync_pkg::*;

  // ************************************
  // state
  // ************************************
  typedef struct packed {
    link_state_t st;
    logic        req_n;
    logic        ref_prev;
    sync_ctl_t   out;
  } state_t;

  state_t     s_q;
  state_t     s_d;
  sync_pins_t pins_s;

  pin_sync #(
    .WIDTH     (3),
    // request pins rest released high and the reference rests low, so no false edge
    .RESET_VAL ({SYNC_RESET_VAL, 1'b0})
  ) u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in (pins),
    .sync_out (pins_s)
  );

  // ************************************
  // request selection
  // ************************************
  function automatic logic pick_req(input sync_cfg_t c, input sync_pins_t p);
    logic r;
    r = 1'b1;
    if (c.sync_source_select == SYNC_SEL_SINGLE) begin
      r = p.single_ended_link_sync_pin_n;
    end else if (c.marker_receiver_enable == MARKER_ON) begin
      r = p.diff_marker_input_pair_n;
    end
    // disabled marker receiver reads as idle high
    return r;
  endfunction

  logic req_n_now;
  assign req_n_now = pick_req(cfg, pins_s);

  always_comb begin
    s_d                 = s_q;
    s_d.req_n           = req_n_now;
    s_d.ref_prev        = pins_s.sysref;
    s_d.out.ilas_start  = 1'b0;
    s_d.out.nco_sync    = 1'b0;
    s_d.out.sysref_edge = pins_s.sysref & ~s_q.ref_prev;
    if (s_q.req_n & ~req_n_now) begin
      // falling edge still usable for nco alignment in any encoding
      s_d.out.nco_sync = 1'b1;
    end
    if (cfg.encoding_mode == ENC_64B66B) begin
      s_d.st             = ST_DATA;
      s_d.out.cgs_active = 1'b0;
    end else begin
      // a low request seen in data state restarts the link from code group sync
      case (s_q.st)
        ST_IDLE, ST_DATA: begin
          if (!req_n_now) begin
            s_d.st             = ST_CGS;
            s_d.out.cgs_active = 1'b1;
          end
        end
        ST_CGS: begin
          if (req_n_now) begin
            s_d.st             = ST_DATA;
            s_d.out.cgs_active = 1'b0;
            s_d.out.ilas_start = 1'b1;
          end else begin
            s_d.out.cgs_active = 1'b1;
          end
        end
        default: begin
          s_d.st             = ST_IDLE;
          s_d.out.cgs_active = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '{st: ST_IDLE, req_n: 1'b1, ref_prev: 1'b0, out: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ctl        = s_q.out;
  assign sync_req_n = s_q.req_n;

  // ************************************
  // checks
  // ************************************
  sequence req_fall;
    $past(req_n_now) && !req_n_now;
  endsequence

  sequence req_rise_in_cgs;
    s_q.st == ST_CGS && req_n_now;
  endsequence

  a_cgs_on_low: assert property (@(posedge sys_clk) disable iff (srst)
    (cfg.encoding_mode == ENC_8B10B && !req_n_now && $stable(cfg)) |=> ctl.cgs_active)
    else $error("cgs not active after low request");

  a_ilas_on_rise: assert property (@(posedge sys_clk) disable iff (srst)
    ((cfg.encoding_mode == ENC_8B10B) and req_rise_in_cgs) |=>
      ctl.ilas_start ##1 !ctl.ilas_start)
    else $error("ilas start not a single pulse on rise");

  a_no_cgs_64b: assert property (@(posedge sys_clk) disable iff (srst)
    cfg.encoding_mode == ENC_64B66B |=> !ctl.cgs_active && !ctl.ilas_start)
    else $error("link init in 64b66b mode");

  a_nco_on_fall: assert property (@(posedge sys_clk) disable iff (srst)
    req_fall |=> ctl.nco_sync)
    else $error("nco sync missing on request fall");

  a_single_src: assert property (@(posedge sys_clk) disable iff (srst)
    cfg.sync_source_select == SYNC_SEL_SINGLE |->
      req_n_now == pins_s.single_ended_link_sync_pin_n)
    else $error("single-ended pin not selected");

  a_diff_src: assert property (@(posedge sys_clk) disable iff (srst)
    (cfg.sync_source_select == SYNC_SEL_DIFF && cfg.marker_receiver_enable) |->
      req_n_now == pins_s.diff_marker_input_pair_n)
    else $error("marker pair not selected");

  a_marker_off: assert property (@(posedge sys_clk) disable iff (srst)
    (cfg.sync_source_select == SYNC_SEL_DIFF && !cfg.marker_receiver_enable) |-> req_n_now)
    else $error("disabled marker pair honoured");

  a_cgs_hold: assert property (@(posedge sys_clk) disable iff (srst)
    (ctl.cgs_active && !req_n_now && cfg.encoding_mode == ENC_8B10B) |=> ctl.cgs_active)
    else $error("cgs dropped while request low");

  a_ref_edge: assert property (@(posedge sys_clk) disable iff (srst)
    ($rose(pins_s.sysref)) |=> ctl.sysref_edge ##1 !ctl.sysref_edge)
    else $error("reference edge not flagged once");

  a_diff_low_act: assert property (@(posedge sys_clk) disable iff (srst)
    (cfg.sync_source_select == SYNC_SEL_DIFF && cfg.marker_receiver_enable &&
     !pins_s.diff_marker_input_pair_n) |=> !sync_req_n)
    else $error("marker pair not active low");

  // ************************************
  // checks: pulse shapes, pulse causes and output levels
  // ************************************
  // a strobe held for two cycles would make the transmitter restart its sequence
  sequence one_cycle_ilas;
    ctl.ilas_start ##1 !ctl.ilas_start;
  endsequence

  sequence one_cycle_nco;
    ctl.nco_sync ##1 !ctl.nco_sync;
  endsequence

  sequence one_cycle_ref;
    ctl.sysref_edge ##1 !ctl.sysref_edge;
  endsequence

  a_ilas_one_cycle: assert property (@(posedge sys_clk) disable iff (srst)
    ctl.ilas_start |-> one_cycle_ilas)
    else $error("ilas start longer than one cycle");

  a_nco_one_cycle: assert property (@(posedge sys_clk) disable iff (srst)
    ctl.nco_sync |-> one_cycle_nco)
    else $error("nco sync longer than one cycle");

  a_ref_one_cycle: assert property (@(posedge sys_clk) disable iff (srst)
    ctl.sysref_edge |-> one_cycle_ref)
    else $error("reference edge longer than one cycle");

  a_ilas_after_cgs: assert property (@(posedge sys_clk) disable iff (srst)
    ctl.ilas_start |-> ($past(ctl.cgs_active) && !ctl.cgs_active))
    else $error("ilas start without preceding cgs");

  a_cgs_drop_high: assert property (@(posedge sys_clk) disable iff (srst)
    (cfg.encoding_mode == ENC_8B10B && req_n_now) |=> !ctl.cgs_active)
    else $error("cgs still active after request high");

  a_marker_off_level: assert property (@(posedge sys_clk) disable iff (srst)
    (cfg.sync_source_select == SYNC_SEL_DIFF && !cfg.marker_receiver_enable) |=> sync_req_n)
    else $error("disabled marker pair reached request output");

  a_single_low_req: assert property (@(posedge sys_clk) disable iff (srst)
    (cfg.sync_source_select == SYNC_SEL_SINGLE &&
     !pins_s.single_ended_link_sync_pin_n) |=> !sync_req_n)
    else $error("single-ended low request not taken");

  a_nco_fall_only: assert property (@(posedge sys_clk) disable iff (srst)
    ctl.nco_sync |-> ($past(sync_req_n) && !sync_req_n))
    else $error("nco sync without request fall");

  a_ref_edge_cause: assert property (@(posedge sys_clk) disable iff (srst)
    ctl.sysref_edge |-> ($past(pins_s.sysref) && !$past(pins_s.sysref, 2)))
    else $error("reference edge flagged without rise");

endmodule

/* link_sync_ctrl_tb.sv */
// self-checking bench for the link sync input control
`timescale 1ns/1ps
module link_sync_ctrl_tb;
  import sync_pkg::*;
  logic       sys_clk = 1'b0;
  logic       srst = 1'b1;
  logic       want_sync = 1'b0;
  logic       use_diff = 1'b0;
  logic       sysref = 1'b0;
  logic       se_n;
  logic       diff_n;
  sync_cfg_t  cfg = '0;
  sync_pins_t pins;
  sync_ctl_t  ctl;
  logic       sync_req_n;
  int         error_cnt = 0;
  int         checked = 0;

  assign pins = '{se_n, diff_n, sysref};

  link_sync_ctrl DUT (.sys_clk(sys_clk), .srst(srst), .cfg(cfg), .pins(pins),
                      .ctl(ctl), .sync_req_n(sync_req_n));
  sync_partner far_end (.sys_clk(sys_clk), .want_sync(want_sync), .use_diff(use_diff),
                        .se_n(se_n), .diff_n(diff_n));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************
  // helpers
  // ****************
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // three edges from pin to outputs: two synchroniser stages plus the register
  task automatic pulse_req(input sync_cfg_t c, output logic [19:0] v);
    cfg = c;
    use_diff = c.sync_source_select;
    step(4);
    want_sync = 1'b1;
    step(3);
    v[19:15] = {ctl, sync_req_n};
    step(1);
    v[14:10] = {ctl, sync_req_n};
    want_sync = 1'b0;
    step(3);
    v[9:5] = {ctl, sync_req_n};
    step(1);
    v[4:0] = {ctl, sync_req_n};
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic single_8b10b();
    logic [19:0] v;
    pulse_req('{SYNC_SEL_SINGLE, ~MARKER_ON, ENC_8B10B, 1'b0}, v);
    chk(v[19:15], 5'h14);
    chk(v[14:10], 5'h10);
    chk(v[9:5], 5'h09);
    chk(v[4:0], 5'h01);
  endtask

  task automatic single_64b66b();
    logic [19:0] v;
    pulse_req('{SYNC_SEL_SINGLE, MARKER_ON, ENC_64B66B, 1'b1}, v);
    chk(v[19:15], 5'h04);
    chk(v[9:5], 5'h01);
  endtask

  task automatic marker_on();
    logic [19:0] v;
    pulse_req('{SYNC_SEL_DIFF, MARKER_ON, ENC_8B10B, 1'b0}, v);
    chk(v[19:15], 5'h14);
    chk(v[9:5], 5'h09);
  endtask

  task automatic marker_off();
    logic [19:0] v;
    pulse_req('{SYNC_SEL_DIFF, ~MARKER_ON, ENC_8B10B, 1'b0}, v);
    chk(v[19:15], 5'h01);
    chk(v[9:5], 5'h01);
  endtask

  task automatic ref_edge();
    sysref = 1'b1;
    step(3);
    chk({ctl, sync_req_n}, 5'h03);
    step(1);
    chk({ctl, sync_req_n}, 5'h01);
    sysref = 1'b0;
  endtask

  task automatic end_sim();
    $display("errors %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    step(8);
    srst = 1'b0;
    single_8b10b();
    single_64b66b();
    marker_on();
    marker_off();
    ref_edge();
    end_sim();
  end

  // whole run is about sixty cycles
  initial begin
    #5000;
    error_cnt++;
    end_sim();
  end
endmodule

/* pin_sync.sv */
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int                 WIDTH = 3,
  parameter logic [WIDTH-1:0]   RESET_VAL = '1
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* sync_partner.sv */
// far-side receiver model driving the link sync request pins
`timescale 1ns/1ps
module sync_partner (
  input  wire logic sys_clk,
  input  wire logic want_sync,
  input  wire logic use_diff,
  output logic      se_n,
  output logic      diff_n
);
  logic tgl_q = 1'b0;

  // an unused marker pair wanders, so a wrong selection shows up
  always_ff @(negedge sys_clk) begin
    tgl_q <= ~tgl_q;
  end

  // single-ended pin tied low while the pair carries the request
  assign se_n   = use_diff ? 1'b0 : ~want_sync;
  assign diff_n = use_diff ? ~want_sync : tgl_q;
endmodule

/* sync_pkg.sv */
// package: constants and carrier types for the link sync input control
package sync_pkg;

  localparam logic       SYNC_SEL_SINGLE = 1'b0;
  localparam logic       SYNC_SEL_DIFF   = 1'b1;
  localparam logic       MARKER_ON       = 1'b1;
  localparam int         SYNC_STAGES     = 2;
  localparam logic [1:0] SYNC_RESET_VAL  = 2'h3;
  localparam logic       ENC_8B10B       = 1'b0;
  localparam logic       ENC_64B66B      = 1'b1;

  // static configuration bits
  typedef struct packed {
    logic sync_source_select;
    logic marker_receiver_enable;
    logic encoding_mode;
    logic reference_dc_coupling_enable;
  } sync_cfg_t;

  // raw pin levels, all asynchronous to sys_clk
  typedef struct packed {
    logic single_ended_link_sync_pin_n;
    logic diff_marker_input_pair_n;
    logic sysref;
  } sync_pins_t;

  // requests handed to the transmitter
  typedef struct packed {
    logic cgs_active;
    logic ilas_start;
    logic nco_sync;
    logic sysref_edge;
  } sync_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CGS  = 3'b010,
    ST_DATA = 3'b100
  } link_state_t;

endpackage
